// ---- tb_top.sv ----
// self-checking bench of the triangle pwm compare stage
`timescale 1ns/10ps
module tb_top
  import tpw_pkg::*;
;
  // bus, control and observation
  logic              hclk    = 1'b0;
  logic              hresetn = 1'b0;
  logic              ce      = 1'b1;
  logic              hsel    = 1'b0;
  logic [DATA_W-1:0] haddr   = '0;
  logic [1:0]        htrans  = 2'h0;
  logic              hwrite  = 1'b0;
  logic [DATA_W-1:0] hwdata  = '0;
  logic [DATA_W-1:0] hrdata;
  logic              hreadyout;
  logic              hresp;
  wire logic         hready  = hreadyout;
  tpw_gate_t         gate;
  int                tog_pos, tog_neg, overlap;
  int                n_fail  = 0;
  int                n_tests = 0;
  int                p, a, b, sp;
  logic [DATA_W-1:0] rd;

  always #12.5 hclk = ~hclk;

  tpw_core tpw_core_i (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .gate(gate));

  tpw_drv_model tpw_drv_model_i (.hclk(hclk), .hresetn(hresetn), .gate(gate),
    .tog_pos(tog_pos), .tog_neg(tog_neg), .overlap(overlap));

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    n_tests++;
    if (seen !== want) begin
      n_fail++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  // one single ahb transfer; entered just after a rising edge
  task automatic xfer(input logic [7:0] ad, input logic wr, input logic [31:0] wd, output logic [31:0] q);
    int k;
    k = 0;
    hsel   <= 1'b1;
    haddr  <= {24'h000000, ad};
    htrans <= 2'h2;
    hwrite <= wr;
    do begin @(posedge hclk); k++; end while (hready !== 1'b1 && k < 50);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge hclk); k++; end while (hready !== 1'b1 && k < 100);
    q = hrdata;
    if (k >= 100) begin n_fail++; tally_and_finish(); end
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic [31:0] q;
    xfer(ad, 1'b1, d, q);
  endtask

  task automatic rchk(input logic [7:0] ad, input logic [31:0] want);
    xfer(ad, 1'b0, 32'h0, rd);
    check(rd, want);
    check(hresp, HRESP_OKAY);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  // poll status until direction matches and count is below a limit; bounded
  task automatic poll(input logic upw, input int lim);
    int k;
    for (k = 0; k < 400; k++) begin
      xfer(OFS_STATUS, 1'b0, 32'h0, rd);
      if (rd[STAT_UP_BIT] === upw && rd[15:0] < lim) break;
    end
    if (k == 400) begin n_fail++; tally_and_finish(); end
  endtask

  // count gate edges over whole periods; a window of full periods needs no alignment
  task automatic meas(input int per, input int wp, input int wn);
    int s0, s1;
    s0 = tog_pos;
    s1 = tog_neg;
    cyc(per * 2 * p);
    check(tog_pos - s0, wp);
    check(tog_neg - s1, wn);
  endtask

  // matches in one period 0..p..1; a cycle matching both registers toggles once
  function automatic int exp_tog(input int pr, input int ca, input int cb);
    int n;
    n = 0;
    for (int k = 0; k < 2 * pr; k++) begin
      int v;
      v = (k <= pr) ? k : 2 * pr - k;
      if (v == ca || v == cb) n++;
    end
    return n;
  endfunction

  initial begin
    void'($urandom(51732));
    cyc(8);
    hresetn <= 1'b1;
    cyc(1);
    // reset values, an unmapped word and a read-only compare
    rchk(OFS_CTRL, 32'h0000_0004);
    rchk(OFS_STATUS, 32'h0001_0000);
    rchk(8'h20, 32'h0000_0000);
    wr(OFS_POS_CMP, 32'h0000_FFFF);
    rchk(OFS_POS_CMP, 32'h0000_0000);
    $display("test registers done");
    // dead-time on in mode 2: normal, hold on above-period value, return at crest
    p = 16 + $urandom_range(14);
    a = 5 + $urandom_range(3);
    b = 1 + $urandom_range(2);
    wr(OFS_PERIOD, p);
    wr(OFS_POS_BUF, a);
    wr(OFS_DEAD_TIME, b);
    wr(OFS_CTRL, 32'h0000_000B);
    cyc(6 * p);
    meas(2, 4, 4);
    check(overlap, 0);
    wr(OFS_POS_BUF, p + 3);
    cyc(3 * p);
    xfer(OFS_STATUS, 1'b0, 32'h0, rd);
    check(rd[STAT_PROT_LSB +: 2], 2'h1);
    meas(2, 0, 0);
    poll(1'b1, 5);
    wr(OFS_POS_BUF, a);
    poll(1'b0, p);
    check(rd[STAT_PROT_LSB +: 2], 2'h3);
    sp = tog_pos + tog_neg;
    poll(1'b0, 5);
    check(tog_pos + tog_neg, sp);
    cyc(3 * p);
    meas(2, 4, 4);
    check(overlap, 0);
    $display("test protection done");
    // dead-time off: abnormal values act directly, modes 1 to 3, corners then random
    for (int m = 1; m < 4; m++) begin
      for (int i = 0; i < 5; i++) begin
        p = 6 + $urandom_range(24);
        b = 1 + $urandom_range(p - 2);
        a = (i == 0) ? 0 : (i == 1) ? p : (i == 2) ? p + 1 + $urandom_range(9) : $urandom_range(p + 2);
        if (i == 4) b = p + 1;
        wr(OFS_PERIOD, p);
        wr(OFS_POS_BUF, a);
        wr(OFS_NEG_BUF, b);
        wr(OFS_CTRL, {28'h0000000, m[1:0], 2'h1});
        cyc(4 * p + 64);
        xfer(OFS_STATUS, 1'b0, 32'h0, rd);
        check(rd[STAT_PROT_LSB +: 2], 2'h0);
        meas(2, 2 * exp_tog(p, a, b), 2 * exp_tog(p, a, b));
      end
    end
    $display("test abnormal values done");
    // transfer points: mode 2 also loads at the crest, mode 1 only at the trough
    p = 30;
    for (int m = 1; m < 3; m++) begin
      wr(OFS_PERIOD, p);
      wr(OFS_POS_BUF, 32'h0000_000A);
      wr(OFS_NEG_BUF, 32'h0000_0014);
      wr(OFS_CTRL, {28'h0000000, m[1:0], 2'h1});
      cyc(4 * p);
      poll(1'b1, 5);
      wr(OFS_POS_BUF, 32'h0000_000C);
      wr(OFS_NEG_BUF, 32'h0000_0016);
      poll(1'b0, p);
      rchk(OFS_POS_CMP, (m == 2) ? 32'h0000_000C : 32'h0000_000A);
      rchk(OFS_NEG_CMP, (m == 2) ? 32'h0000_0016 : 32'h0000_0014);
    end
    $display("test transfer points done");
    // freeze: ce low for a whole period stops a toggling pwm, then one full period resumes it
    ce <= 1'b0;
    cyc(2);
    a = tog_pos;
    b = tog_neg;
    cyc(2 * p);
    check(tog_pos, a);
    check(tog_neg, b);
    ce <= 1'b1;
    // two extra edges cover the lag of the driver model behind the gate
    cyc(2 * p + 2);
    check(tog_pos - a, exp_tog(p, 12, 22));
    check(tog_neg - b, exp_tog(p, 12, 22));
    $display("test clock enable done");
    tally_and_finish();
  end
endmodule // tb_top

// ---- tpw_core.sv ----
// triangle-wave complementary pwm compare and output stage with ahb-lite registers
`timescale 1ns/10ps
module tpw_core
  import tpw_pkg::*;
(
  // clock, reset, freeze
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              ce,
  // ahb-lite slave
  input  wire logic              hsel,
  input  wire logic [DATA_W-1:0] haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [DATA_W-1:0] hwdata,
  input  wire logic              hready,
  output logic      [DATA_W-1:0] hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  // gate drive
  output tpw_gate_t              gate
);

  tpw_state_t st;
  tpw_state_t next_st;

  logic crest;
  logic trough;
  logic pos_hit;
  logic neg_hit;
  logic xfer;
  logic bus_take;

  // zero or beyond the period counts as abnormal
  function automatic logic is_abnormal(input logic [CNT_W-1:0] v, input logic [CNT_W-1:0] per);
    is_abnormal = (v == CNT_ZERO) || (v > per);
  endfunction

  // word-aligned decode shared by read and write paths
  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    addr_is = (a == ofs);
  endfunction

  // dead-time point, saturated so a large dead time never wraps to a low count
  function automatic logic [CNT_W-1:0] dt_point(input logic [CNT_W-1:0] c, input logic [CNT_W-1:0] d);
    logic [CNT_W:0] sum;
    sum = {1'b0, c} + {1'b0, d};
    dt_point = sum[CNT_W] ? CNT_MAX : sum[CNT_W-1:0];
  endfunction

  // zero-extend a counter-width field onto the bus
  function automatic logic [DATA_W-1:0] widen(input logic [CNT_W-1:0] v);
    widen = {{(DATA_W-CNT_W){1'b0}}, v};
  endfunction

  function automatic logic [DATA_W-1:0] read_word(input logic [ADDR_W-1:0] a, input tpw_state_t s);
    logic [DATA_W-1:0] w;
    w = '0;
    if (addr_is(a, OFS_CTRL)) begin
      w[CTRL_RUN_BIT] = s.run;
      w[CTRL_DT_BIT] = s.dt_en;
      w[CTRL_MODE_LSB +: MODE_W] = s.mode;
    end
    else if (addr_is(a, OFS_PERIOD)) begin
      w = widen(s.period_setting);
    end
    else if (addr_is(a, OFS_POS_BUF)) begin
      w = widen(s.pos_phase_buffer);
    end
    else if (addr_is(a, OFS_NEG_BUF)) begin
      w = widen(s.neg_phase_buffer);
    end
    else if (addr_is(a, OFS_DEAD_TIME)) begin
      w = widen(s.dead_time_up_value);
    end
    else if (addr_is(a, OFS_STATUS)) begin
      w[CNT_W-1:0] = s.cnt;
      w[STAT_UP_BIT] = s.up;
      w[STAT_PROT_LSB +: 2] = s.prot;
      w[STAT_POS_BIT] = s.gate.pos;
      w[STAT_NEG_BIT] = s.gate.neg;
    end
    else if (addr_is(a, OFS_POS_CMP)) begin
      w = widen(s.pos_phase_compare);
    end
    else if (addr_is(a, OFS_NEG_CMP)) begin
      w = widen(s.neg_phase_compare);
    end
    read_word = w;
  endfunction

  // extremes of the triangle and compare matches
  assign crest    = st.run && st.up && (st.cnt >= st.period_setting);
  assign trough   = st.run && !st.up && (st.cnt == CNT_ZERO);
  assign pos_hit  = st.run && (st.cnt == st.pos_phase_compare);
  assign neg_hit  = st.run && (st.cnt == st.neg_phase_compare);
  // only mode 2 reloads at the crest too; mode 3 differs from mode 1 in nothing else here
  assign xfer     = trough || (crest && (st.mode == TPW_MODE_2));
  assign bus_take = hsel && hready && htrans[HTRANS_ACT_BIT];

  // next-state logic
  always_comb begin
    next_st = st;

    // data phase of a write: zero wait states, so hwdata is taken right away
    next_st.wr_pend = 1'b0;
    if (st.wr_pend) begin
      if (addr_is(st.wr_addr, OFS_CTRL)) begin
        next_st.run = hwdata[CTRL_RUN_BIT];
        next_st.dt_en = hwdata[CTRL_DT_BIT];
        next_st.mode = tpw_mode_t'(hwdata[CTRL_MODE_LSB +: MODE_W]);
      end
      else if (addr_is(st.wr_addr, OFS_PERIOD)) begin
        next_st.period_setting = hwdata[CNT_W-1:0];
      end
      else if (addr_is(st.wr_addr, OFS_POS_BUF)) begin
        next_st.pos_phase_buffer = hwdata[CNT_W-1:0];
      end
      else if (addr_is(st.wr_addr, OFS_NEG_BUF)) begin
        next_st.neg_phase_buffer = hwdata[CNT_W-1:0];
      end
      else if (addr_is(st.wr_addr, OFS_DEAD_TIME)) begin
        next_st.dead_time_up_value = hwdata[CNT_W-1:0];
      end
    end

    // address phase: read data is latched now so it stands in the data phase
    if (bus_take) begin
      next_st.wr_pend = hwrite;
      next_st.wr_addr = haddr[ADDR_W-1:0];
      next_st.hrdata = hwrite ? '0 : read_word(haddr[ADDR_W-1:0], st);
    end
    next_st.hreadyout = 1'b1;
    next_st.hresp = HRESP_OKAY;

    // up/down counter, each extreme lasts exactly one count
    if (st.run && (st.period_setting != CNT_ZERO)) begin
      if (crest) begin
        next_st.up = 1'b0;
        next_st.cnt = st.period_setting - CNT_ONE;
      end
      else if (trough) begin
        next_st.up = 1'b1;
        next_st.cnt = CNT_ONE;
      end
      else if (st.up) begin
        next_st.cnt = st.cnt + CNT_ONE;
      end
      else begin
        next_st.cnt = st.cnt - CNT_ONE;
      end
    end

    // buffer to compare transfer; with dead time on the negative compare comes from the positive buffer plus dead time
    if (xfer) begin
      next_st.pos_phase_compare = st.pos_phase_buffer;
      if (st.dt_en) begin
        next_st.neg_phase_compare = dt_point(st.pos_phase_buffer, st.dead_time_up_value);
      end
      else begin
        next_st.neg_phase_compare = st.neg_phase_buffer;
      end
    end

    // protection state: a crest return waits for the trough before releasing
    if (!st.dt_en) begin
      next_st.prot = TPW_PROT_NORMAL;
    end
    else begin
      case (st.prot)
        TPW_PROT_NORMAL: begin
          if (xfer && is_abnormal(st.pos_phase_buffer, st.period_setting)) begin
            next_st.prot = TPW_PROT_HOLD;
          end
        end
        TPW_PROT_HOLD: begin
          if (xfer && !is_abnormal(st.pos_phase_buffer, st.period_setting)) begin
            next_st.prot = crest ? TPW_PROT_RETURN : TPW_PROT_NORMAL;
          end
        end
        TPW_PROT_RETURN: begin
          if (xfer && is_abnormal(st.pos_phase_buffer, st.period_setting)) begin
            next_st.prot = TPW_PROT_HOLD;
          end
          else if (trough) begin
            next_st.prot = TPW_PROT_NORMAL;
          end
        end
        default: begin
          next_st.prot = TPW_PROT_NORMAL;
        end
      endcase
    end

    // gate outputs: level compare with protection, toggle on match without it
    if (st.run) begin
      if (st.dt_en) begin
        if (st.prot == TPW_PROT_NORMAL) begin
          next_st.gate.pos = st.cnt < st.pos_phase_compare;
          next_st.gate.neg = st.cnt >= st.neg_phase_compare;
        end
        // holding and returning keep the levels, matches are ignored
      end
      else if (pos_hit || neg_hit) begin
        // zero matches only at the trough, period only at the crest
        next_st.gate.pos = !st.gate.pos;
        next_st.gate.neg = !st.gate.neg;
      end
      // no match: levels stay, above-period values never reach here
    end
  end

  // single state register, frozen while ce is low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= TPW_STATE_RST;
    end
    else if (ce) begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign hrdata    = st.hrdata;
  assign hreadyout = st.hreadyout;
  assign hresp     = st.hresp;
  assign gate      = st.gate;

  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_hold_step;
    ce && st.run && st.dt_en && (st.prot == TPW_PROT_HOLD);
  endsequence

  sequence s_return_step;
    ce && st.run && st.dt_en && (st.prot == TPW_PROT_RETURN);
  endsequence

  sequence s_zero_trough;
    ce && !st.dt_en && trough && (st.pos_phase_compare == CNT_ZERO);
  endsequence

  AST_HOLD_FREEZES: assert property (s_hold_step |=> $stable(st.gate))
    else $error("gate moved while protection holds");

  AST_RETURN_FREEZES: assert property (s_return_step |=> $stable(st.gate))
    else $error("gate moved in return interval");

  AST_PROT_OFF: assert property (ce && !st.dt_en |=> st.prot == TPW_PROT_NORMAL)
    else $error("protection active with dead time off");

  AST_NO_MATCH_STILL: assert property (ce && !st.dt_en && !pos_hit && !neg_hit |=> $stable(st.gate))
    else $error("gate toggled without a compare match");

  AST_ZERO_TOGGLES: assert property (s_zero_trough |=> (st.gate.pos != $past(st.gate.pos))
                                     && (st.gate.neg != $past(st.gate.neg)))
    else $error("zero compare did not toggle both phases at trough");

  // a crest reached above a freshly lowered period is no match, so the count must sit on the period itself
  AST_CREST_TOGGLES: assert property (ce && !st.dt_en && crest && (st.cnt == st.period_setting)
                                      && (st.pos_phase_compare == st.period_setting)
                                      |=> st.gate != $past(st.gate))
    else $error("period compare did not toggle at crest");

  AST_NEG_TOGGLES: assert property (ce && !st.dt_en && neg_hit && !pos_hit
                                    |=> (st.gate.pos != $past(st.gate.pos)) && (st.gate.neg != $past(st.gate.neg)))
    else $error("negative match did not toggle both phases");

  AST_MODE2_CREST: assert property (ce && crest && (st.mode == TPW_MODE_2)
                                    |=> st.pos_phase_compare == $past(st.pos_phase_buffer))
    else $error("mode 2 missed crest transfer");

  AST_CREST_ONLY_M2: assert property (ce && crest && (st.mode != TPW_MODE_2) && !trough
                                      |=> $stable(st.pos_phase_compare))
    else $error("crest transfer outside mode 2");

  AST_OWN_BUFFER: assert property (ce && trough && !st.dt_en
                                   |=> st.neg_phase_compare == $past(st.neg_phase_buffer))
    else $error("negative compare not from its own buffer");

  AST_DT_POINT: assert property (ce && xfer && st.dt_en
                                 |=> st.neg_phase_compare == dt_point(st.pos_phase_compare, $past(st.dead_time_up_value)))
    else $error("dead-time point wrong");

  AST_TRIANGLE: assert property (ce && st.run && !st.up && (st.cnt != CNT_ZERO) && (st.period_setting != CNT_ZERO)
                                 ##1 ce |-> st.cnt == $past(st.cnt) - CNT_ONE)
    else $error("down count did not step by one");

endmodule  // tpw_core

// ---- tpw_drv_model.sv ----
// behavioural gate-driver pair that counts edges and overlap on the complementary gates
`timescale 1ns/10ps
module tpw_drv_model
  import tpw_pkg::*;
(
  // clock and reset
  input  wire logic      hclk,
  input  wire logic      hresetn,
  // gates from the compare stage
  input  wire tpw_gate_t gate,
  // observed activity
  output int             tog_pos,
  output int             tog_neg,
  output int             overlap
);
  tpw_gate_t last;

  // the power stage only sees levels at the clock, so count changes edge to edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tog_pos <= 0;
      tog_neg <= 0;
      overlap <= 0;
      last    <= '0;
    end else begin
      if (gate.pos !== last.pos) tog_pos <= tog_pos + 1;
      if (gate.neg !== last.neg) tog_neg <= tog_neg + 1;
      // both switches on at once would short the leg
      if (gate.pos === 1'b1 && gate.neg === 1'b1) overlap <= overlap + 1;
      last <= gate;
    end
  end
endmodule // tpw_drv_model

// ---- tpw_pkg.sv ----
// constants, register map and state types of the triangle pwm compare stage
package tpw_pkg;

  // widths
  localparam int unsigned DATA_W = 32;
  localparam int unsigned CNT_W  = 16;
  localparam int unsigned ADDR_W = 8;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL      = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PERIOD    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_POS_BUF   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_NEG_BUF   = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_DEAD_TIME = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_POS_CMP   = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_NEG_CMP   = 8'h1C;

  // control register fields
  localparam int unsigned CTRL_RUN_BIT  = 0;
  localparam int unsigned CTRL_DT_BIT   = 1;
  localparam int unsigned CTRL_MODE_LSB = 2;
  localparam int unsigned MODE_W        = 2;

  // status register fields
  localparam int unsigned STAT_UP_BIT   = 16;
  localparam int unsigned STAT_PROT_LSB = 17;
  localparam int unsigned STAT_POS_BIT  = 19;
  localparam int unsigned STAT_NEG_BIT  = 20;

  // counter steps and special compare values
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_MAX  = 16'hFFFF;

  // ahb encodings
  localparam int unsigned HTRANS_ACT_BIT = 1;
  localparam logic        HRESP_OKAY     = 1'b0;

  // triangle modes: mode 2 transfers at crest and trough, the others at trough
  typedef enum logic [MODE_W-1:0] {
    TPW_MODE_NONE = 2'h0,
    TPW_MODE_1    = 2'h1,
    TPW_MODE_2    = 2'h2,
    TPW_MODE_3    = 2'h3
  } tpw_mode_t;

  // output protection states, gray along normal -> hold -> return
  typedef enum logic [1:0] {
    TPW_PROT_NORMAL = 2'b00,
    TPW_PROT_HOLD   = 2'b01,
    TPW_PROT_RETURN = 2'b11
  } tpw_prot_t;

  // complementary gate pair
  typedef struct packed {
    logic pos;
    logic neg;
  } tpw_gate_t;

  // whole state of the block
  typedef struct packed {
    logic [CNT_W-1:0]  cnt;
    logic              up;
    logic              run;
    logic              dt_en;
    tpw_mode_t         mode;
    logic [CNT_W-1:0]  period_setting;
    logic [CNT_W-1:0]  pos_phase_buffer;
    logic [CNT_W-1:0]  neg_phase_buffer;
    logic [CNT_W-1:0]  dead_time_up_value;
    logic [CNT_W-1:0]  pos_phase_compare;
    logic [CNT_W-1:0]  neg_phase_compare;
    tpw_prot_t         prot;
    tpw_gate_t         gate;
    logic              wr_pend;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] hrdata;
    logic              hreadyout;
    logic              hresp;
  } tpw_state_t;

  localparam tpw_state_t TPW_STATE_RST = '{
    cnt: CNT_ZERO, up: 1'b1, run: 1'b0, dt_en: 1'b0, mode: TPW_MODE_1,
    period_setting: CNT_ZERO, pos_phase_buffer: CNT_ZERO, neg_phase_buffer: CNT_ZERO,
    dead_time_up_value: CNT_ZERO, pos_phase_compare: CNT_ZERO, neg_phase_compare: CNT_ZERO,
    prot: TPW_PROT_NORMAL, gate: '{pos: 1'b0, neg: 1'b0}, wr_pend: 1'b0, wr_addr: 8'h00,
    hrdata: 32'h0000_0000, hreadyout: 1'b1, hresp: HRESP_OKAY
  };

endpackage
